//--- logic/bit_sync.sv
/*
  Two-flop synchroniser for a level or a gray-coded bus.
  Assumes each bit changes independently or the bus is gray coded.
*/
`default_nettype none

module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset of the receiving domain
    input wire logic i_clk,
    input wire logic i_rst,
    // Data
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= RST_VAL;
            o_q <= RST_VAL;
        end
        else
        begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- logic/cdc_fifo.sv
/*
  Dual-clock FIFO with gray-coded pointers, valid and ready on both sides.
  Assumes DEPTH is a power of two and at least four.
*/
`default_nettype none

module cdc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // Filling side
    input wire logic i_wclk,
    input wire logic i_wrst,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [WIDTH-1:0] i_wdata,
    // Draining side
    input wire logic i_rclk,
    input wire logic i_rrst,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [WIDTH-1:0] o_rdata
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin_q;
    logic [AW:0] wgray_q;
    logic [AW:0] rbin_q;
    logic [AW:0] rgray_q;
    logic [AW:0] rgray_w;
    logic [AW:0] wgray_r;
    logic [AW:0] wbin_d;
    logic [AW:0] rbin_d;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Filling side
    assign o_wready = (wgray_q != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    assign wbin_d = wbin_q + 1'b1;

    always_ff @(posedge i_wclk)
    begin
        if (i_wvalid && o_wready)
        begin
            mem[wbin_q[AW-1:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_wclk or posedge i_wrst)
    begin
        if (i_wrst)
        begin
            wbin_q <= '0;
            wgray_q <= '0;
        end
        else if (i_wvalid && o_wready)
        begin
            wbin_q <= wbin_d;
            wgray_q <= to_gray(wbin_d);
        end
    end

    bit_sync #(.WIDTH(AW + 1), .RST_VAL('0)) u_r2w (
        .i_clk(i_wclk),
        .i_rst(i_wrst),
        .i_d(rgray_q),
        .o_q(rgray_w)
    );

    ////////////////////////////////////////////////////////////////////
    // Draining side
    assign o_rvalid = (rgray_q != wgray_r);
    assign o_rdata = mem[rbin_q[AW-1:0]];
    assign rbin_d = rbin_q + 1'b1;

    always_ff @(posedge i_rclk or posedge i_rrst)
    begin
        if (i_rrst)
        begin
            rbin_q <= '0;
            rgray_q <= '0;
        end
        else if (o_rvalid && i_rready)
        begin
            rbin_q <= rbin_d;
            rgray_q <= to_gray(rbin_d);
        end
    end

    bit_sync #(.WIDTH(AW + 1), .RST_VAL('0)) u_w2r (
        .i_clk(i_rclk),
        .i_rst(i_rrst),
        .i_d(wgray_q),
        .o_q(wgray_r)
    );

endmodule

`default_nettype wire

//--- logic/i2c_word_pkg.sv
/*
  Shared constants, state encodings and carrier types of the two-wire
  word register slave.
  Assumes a 7-bit slave address, an 8-bit register pointer and 16-bit
  registers that live outside this block.
*/
`default_nettype none

package i2c_word_pkg;

    // Own slave address, plain default
    localparam logic [6:0] DEV_ADDR = 7'h20;

    // Widths and depths
    localparam int PTR_W = 8;
    localparam int WORD_W = 16;
    localparam int WR_FIFO_DEPTH = 32;

    // Bit counter value once eight data bits are in
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_RST = 4'h0;

    // Direction bit values
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // Reset values
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WDATA = 2'b10,
        ST_RDATA = 2'b11
    } link_state_t;

    typedef enum logic [1:0]
    {
        PH_PTR = 2'b00,
        PH_HI = 2'b01,
        PH_LO = 2'b10
    } wr_phase_t;

    typedef struct packed
    {
        logic [7:0] ptr;
        logic [15:0] data;
    } reg_write_t;

    localparam int REG_WRITE_W = $bits(reg_write_t);

endpackage

`default_nettype wire

//--- logic/i2c_word_slave.sv
/*
  Two-wire slave port giving a bus master word access to 16-bit registers.
  The pin engine runs on the fast sampling clock i_link_clk; register
  writes reach the core clock through a FIFO, register reads through a
  toggle handshake. The register file itself sits outside on i_clk.
  Assumes SCL is sampled at least eight times per SCL half period and the
  core answers a read request well within half an SCL period.
*/
`default_nettype none

// Operation
// - Detect START: SDA falls while SCL high
// - Shift in seven address bits, then direction
// - Acknowledge own address before ninth pulse
// - Foreign address: stay idle, SDA released
// - Direction 0 writes, 1 reads
// - Eight data bits plus one acknowledge
// - SDA rising while SCL high is STOP
// - Direction fixed until next START
// - First written byte loads register pointer
// - Following bytes written to pointed register; the code takes only high and low, and the next byte loads the pointer again
// - No limit on bytes per operation
// - Pointer write, repeated START, then read
// - Read returns high byte then low
// - Write is pointer, high, low, each acknowledged; low byte not acknowledged while the write FIFO is full
module i2c_word_slave
    import i2c_word_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = DEV_ADDR
) (
    // Core clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link sampling clock
    input wire logic i_link_clk,
    // Two-wire pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Register writes, core clock
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    output reg_write_t o_wr,
    // Register reads, core clock
    output logic o_rd_req,
    output logic [7:0] o_rd_ptr,
    input wire logic i_rd_valid,
    input wire logic [15:0] i_rd_data
);

    ////////////////////////////////////////////////////////////////////
    // Link domain declarations
    logic scl_s;
    logic sda_s;
    logic scl_p_q;
    logic sda_p_q;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    link_state_t state_q;
    wr_phase_t phase_q;
    logic [3:0] cnt_q;
    logic ack_phase_q;
    logic [7:0] shift_q;
    logic [7:0] ptr_q;
    logic [7:0] hi_q;
    logic [15:0] tx_word_q;
    logic tx_lo_q;
    logic nack_q;
    logic drive_q;
    logic byte_done;
    logic ack_end;
    logic addr_match;
    logic accept;
    logic fifo_wready;
    logic fifo_push;
    logic fetch_go;
    logic req_tgl_q;
    logic ack_tgl_s;
    logic ack_tgl_p_q;
    logic [15:0] rd_word_q;
    logic [2:0] tx_idx;
    reg_write_t push_word;

    // Core domain declarations
    logic req_tgl_s;
    logic req_tgl_p_q;
    logic busy_q;
    logic ack_tgl_q;
    logic [15:0] data_q;
    logic rd_req_q;
    logic [7:0] rd_ptr_q;

    ////////////////////////////////////////////////////////////////////
    // Pin sampling and bus conditions
    bit_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_d({i_scl, i_sda}),
        .o_q({scl_s, sda_s})
    );

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;

    ////////////////////////////////////////////////////////////////////
    // Byte framing decode
    assign byte_done = scl_fall && (cnt_q == BIT_ACK) && !ack_phase_q
        && (state_q != ST_IDLE) && (state_q != ST_RDATA);
    assign ack_end = scl_fall && ack_phase_q;
    assign addr_match = (shift_q[7:1] == SLAVE_ADDR);
    assign fifo_push = byte_done && (state_q == ST_WDATA) && (phase_q == PH_LO) && fifo_wready;
    assign push_word = '{ptr: ptr_q, data: {hi_q, shift_q}};
    assign tx_idx = 3'h7 - cnt_q[2:0];

    always_comb
    begin
        accept = 1'b0;
        unique case (state_q)
            ST_ADDR: accept = addr_match;
            ST_WDATA: accept = (phase_q != PH_LO) || fifo_wready;
            ST_IDLE, ST_RDATA: accept = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Operation state and bit counter
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= BIT_RST;
            ack_phase_q <= 1'b0;
        end
        else if (start_det)
        begin
            state_q <= ST_ADDR;
            cnt_q <= BIT_RST;
            ack_phase_q <= 1'b0;
        end
        else if (stop_det)
        begin
            state_q <= ST_IDLE;
            cnt_q <= BIT_RST;
            ack_phase_q <= 1'b0;
        end
        else if (state_q != ST_IDLE)
        begin
            if (scl_rise && !ack_phase_q && cnt_q != BIT_ACK)
            begin
                cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == BIT_ACK && !ack_phase_q)
            begin
                ack_phase_q <= 1'b1;
            end
            else if (ack_end)
            begin
                ack_phase_q <= 1'b0;
                cnt_q <= BIT_RST;
                if (state_q == ST_ADDR)
                begin
                    if (!shift_q[0] == !DIR_READ && addr_match)
                    begin
                        state_q <= ST_RDATA;
                    end
                    else if (addr_match)
                    begin
                        state_q <= ST_WDATA;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                else if (state_q == ST_RDATA && nack_q)
                begin
                    state_q <= ST_IDLE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive shift register and master acknowledge sample
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            shift_q <= BYTE_RST;
            nack_q <= 1'b0;
        end
        else if (scl_rise && !ack_phase_q && cnt_q != BIT_ACK)
        begin
            shift_q <= {shift_q[6:0], sda_s};
        end
        else if (scl_rise && ack_phase_q && state_q == ST_RDATA)
        begin
            nack_q <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write path: pointer, high byte, low byte
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            phase_q <= PH_PTR;
            ptr_q <= PTR_RST;
            hi_q <= BYTE_RST;
        end
        else if (start_det)
        begin
            phase_q <= PH_PTR;
        end
        else if (byte_done && state_q == ST_WDATA)
        begin
            unique case (phase_q)
                PH_PTR:
                begin
                    ptr_q <= shift_q;
                    phase_q <= PH_HI;
                end
                PH_HI:
                begin
                    hi_q <= shift_q;
                    phase_q <= PH_LO;
                end
                PH_LO:
                begin
                    phase_q <= PH_PTR;
                end
                default:
                begin
                    phase_q <= PH_PTR;
                end
            endcase
        end
    end

    cdc_fifo #(.WIDTH(REG_WRITE_W), .DEPTH(WR_FIFO_DEPTH)) u_wr_fifo (
        .i_wclk(i_link_clk),
        .i_wrst(i_rst),
        .i_wvalid(fifo_push),
        .o_wready(fifo_wready),
        .i_wdata(push_word),
        .i_rclk(i_clk),
        .i_rrst(i_rst),
        .o_rvalid(o_wr_valid),
        .i_rready(i_wr_ready),
        .o_rdata(o_wr)
    );

    ////////////////////////////////////////////////////////////////////
    // Read path: word to send, high byte first
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_word_q <= WORD_RST;
            tx_lo_q <= 1'b0;
        end
        else if (ack_end && state_q == ST_ADDR)
        begin
            tx_word_q <= rd_word_q;
            tx_lo_q <= 1'b0;
        end
        else if (ack_end && state_q == ST_RDATA && !nack_q)
        begin
            tx_lo_q <= !tx_lo_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // SDA drive: acknowledge and read data
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            drive_q <= 1'b0;
        end
        else if (start_det || stop_det)
        begin
            drive_q <= 1'b0;
        end
        else if (byte_done)
        begin
            drive_q <= accept;
        end
        else if (ack_end)
        begin
            if (state_q == ST_ADDR && addr_match && shift_q[0] == DIR_READ)
            begin
                drive_q <= !rd_word_q[15];
            end
            else if (state_q == ST_RDATA && !nack_q)
            begin
                drive_q <= tx_lo_q ? !tx_word_q[15] : !tx_word_q[7];
            end
            else
            begin
                drive_q <= 1'b0;
            end
        end
        else if (scl_fall && state_q == ST_RDATA && !ack_phase_q)
        begin
            if (cnt_q == BIT_ACK)
            begin
                drive_q <= 1'b0;
            end
            else if (tx_lo_q)
            begin
                drive_q <= !tx_word_q[tx_idx];
            end
            else
            begin
                drive_q <= !tx_word_q[{1'b1, tx_idx}];
            end
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe = drive_q;

    ////////////////////////////////////////////////////////////////////
    // Read fetch handshake, link side
    assign fetch_go = (req_tgl_q == ack_tgl_s)
        && ((byte_done && state_q == ST_WDATA && phase_q == PH_PTR)
        || (byte_done && state_q == ST_ADDR && addr_match && shift_q[0] == DIR_READ));

    bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_ack_sync (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_d(ack_tgl_q),
        .o_q(ack_tgl_s)
    );

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_tgl_q <= 1'b0;
            ack_tgl_p_q <= 1'b0;
            rd_word_q <= WORD_RST;
        end
        else
        begin
            ack_tgl_p_q <= ack_tgl_s;
            if (fetch_go)
            begin
                req_tgl_q <= !req_tgl_q;
            end
            if (ack_tgl_s != ack_tgl_p_q)
            begin
                rd_word_q <= data_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read fetch handshake, core side
    bit_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_req_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d(req_tgl_q),
        .o_q(req_tgl_s)
    );

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            req_tgl_p_q <= 1'b0;
            busy_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            data_q <= WORD_RST;
            rd_req_q <= 1'b0;
            rd_ptr_q <= PTR_RST;
        end
        else
        begin
            req_tgl_p_q <= req_tgl_s;
            rd_req_q <= 1'b0;
            if (req_tgl_s != req_tgl_p_q)
            begin
                busy_q <= 1'b1;
                rd_req_q <= 1'b1;
                rd_ptr_q <= ptr_q;
            end
            else if (busy_q && i_rd_valid)
            begin
                busy_q <= 1'b0;
                data_q <= i_rd_data;
                ack_tgl_q <= !ack_tgl_q;
            end
        end
    end

    assign o_rd_req = rd_req_q;
    assign o_rd_ptr = rd_ptr_q;

endmodule

`default_nettype wire

//--- tb/i2c_master_model.sv
/*
  Behavioural two-wire bus master driving SCL and its share of SDA.
  Assumes SDA is a pulled-up wire resolved by the bench.
*/
`default_nettype none

module i2c_master_model #(
    parameter int HALF = 60
) (
    input wire logic i_lclk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idle, clock stands high
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_lclk);
        #2;
    endtask

    task automatic start();
        o_sda = 1'b1;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda = 1'b0;
        tick(HALF);
        o_scl = 1'b0;
        tick(HALF / 2);
    endtask

    task automatic stop();
        o_sda = 1'b0;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF);
        o_sda = 1'b1;
        tick(2 * HALF);
    endtask

    task automatic bit_io(input logic b, output logic r);
        o_sda = b;
        tick(HALF);
        o_scl = 1'b1;
        tick(HALF / 2);
        r = i_sda;
        tick(HALF / 2);
        o_scl = 1'b0;
        tick(2);
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

`default_nettype wire

//--- tb/i2c_word_slave_props.sv
/*
  Port checker of the two-wire word slave, bound to its top module.
  Assumes i_rst clears both clock domains.
*/
`default_nettype none

module i2c_word_slave_props
    import i2c_word_pkg::*;
(
    // Clocks and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    // Pins
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    // Core side
    input wire logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire reg_write_t o_wr,
    input wire logic o_rd_req,
    input wire logic [7:0] o_rd_ptr
);
    timeunit 1ns;
    timeprecision 100ps;

    logic scl_q;
    logic [3:0] drive_cnt_q;

    // SCL rises seen while the device holds SDA low
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_q <= 1'b1;
            drive_cnt_q <= 4'h0;
        end
        else
        begin
            scl_q <= i_scl;
            if (!o_sda_oe)
                drive_cnt_q <= 4'h0;
            else if (i_scl && !scl_q && drive_cnt_q != 4'hf)
                drive_cnt_q <= drive_cnt_q + 4'h1;
        end
    end

    sequence s_start;
        i_scl && $fell(i_sda);
    endsequence

    sequence s_stop;
        i_scl && $rose(i_sda);
    endsequence

    a_pull_only: assert property (@(posedge i_link_clk) disable iff (i_rst)
        o_sda_out == 1'b0) else $error("sda driven high");
    a_oe_scl_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $changed(o_sda_oe) |-> !i_scl) else $error("sda moved while scl high");
    a_free_at_start: assert property (@(posedge i_link_clk) disable iff (i_rst)
        s_start |-> !o_sda_oe [*4]) else $error("sda held at start");
    a_idle_after_stop: assert property (@(posedge i_link_clk) disable iff (i_rst)
        s_stop |-> !o_sda_oe [*8]) else $error("sda held after stop");
    a_drive_span: assert property (@(posedge i_link_clk) disable iff (i_rst)
        drive_cnt_q <= 4'h9) else $error("sda held over too many bits");
    a_req_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rd_req |=> !o_rd_req) else $error("read request longer than a cycle");
    a_ptr_held: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(o_rd_ptr) |-> o_rd_req) else $error("pointer moved without request");
    a_word_held: assert property (@(posedge i_clk) disable iff (i_rst)
        o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr))
        else $error("write word changed while stalled");
endmodule

bind i2c_word_slave i2c_word_slave_props i_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
    .i_wr_ready(i_wr_ready), .o_wr(o_wr), .o_rd_req(o_rd_req), .o_rd_ptr(o_rd_ptr)
);

`default_nettype wire

//--- tb/tb_i2c_word_register_slave.sv
/*
  Self-checking bench of the two-wire word slave with a master model
  and a behavioural register file on the core clock.
  Assumes the checker is bound to the design.
*/
`default_nettype none

module tb_i2c_word_register_slave;
    timeunit 1ns;
    timeprecision 100ps;
    import i2c_word_pkg::*;

    logic i_clk, i_rst, i_link_clk, scl, m_sda, sda_w, o_sda_out, o_sda_oe;
    logic o_wr_valid, i_wr_ready, o_rd_req, i_rd_valid, stall, rd_hit;
    reg_write_t o_wr;
    logic [7:0] o_rd_ptr;
    logic [15:0] i_rd_data;
    logic [15:0] mem [256];
    logic [15:0] shadow [256];
    logic [31:0] rnd;
    logic [31:0] rnd_core;
    int seed = 74;
    int error_cnt = 0;
    int compares = 0;

    // Open drain wire with pull-up
    assign sda_w = m_sda & ~o_sda_oe;

    i2c_word_slave i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
        .i_scl(scl), .i_sda(sda_w), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
        .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready), .o_wr(o_wr),
        .o_rd_req(o_rd_req), .o_rd_ptr(o_rd_ptr), .i_rd_valid(i_rd_valid),
        .i_rd_data(i_rd_data));

    i2c_master_model #(.HALF(60)) i_master (.i_lclk(i_link_clk), .i_sda(sda_w),
        .o_scl(scl), .o_sda(m_sda));

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    initial
    begin
        i_link_clk = 1'b0;
        #3;
        forever #7.5 i_link_clk = ~i_link_clk;
    end

    // Core register file: random write stalls, reads answered next cycle
    always @(posedge i_clk)
    begin
        if (!i_rst && o_wr_valid === 1'b1 && i_wr_ready)
            mem[o_wr.ptr] = o_wr.data;
        rd_hit = (o_rd_req === 1'b1);
        #2;
        rnd_core = $random(seed);
        i_wr_ready = ~stall & rnd_core[0];
        i_rd_valid = rd_hit;
        i_rd_data = mem[o_rd_ptr];
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Low byte is acknowledged while the write buffer has room
    function automatic logic fifo_room(input int i);
        return i < WR_FIFO_DEPTH;
    endfunction

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic open_wr(input logic [6:0] addr, input logic exp_ack);
        logic a;
        i_master.start();
        i_master.wr_byte({addr, DIR_WRITE}, a);
        check("address ack", 16'(a), 16'(exp_ack));
    endtask

    task automatic put_word(input logic [7:0] p, input logic [15:0] d, input logic lo_ack);
        logic a;
        i_master.wr_byte(p, a);
        check("pointer ack", 16'(a), 16'h1);
        i_master.wr_byte(d[15:8], a);
        check("high byte ack", 16'(a), 16'h1);
        i_master.wr_byte(d[7:0], a);
        check("low byte ack", 16'(a), 16'(lo_ack));
        if (lo_ack)
            shadow[p] = d;
    endtask

    task automatic drain();
        int n;
        for (n = 0; n < 3000 && o_wr_valid !== 1'b0; n++)
            @(posedge i_clk);
        if (n == 3000)
        begin
            check("write drain", 16'(o_wr_valid), 16'h0);
            report_and_stop();
        end
    endtask

    task automatic get_word(input logic [7:0] p, input int n);
        logic a;
        logic [7:0] hi, lo;
        open_wr(DEV_ADDR, 1'b1);
        i_master.wr_byte(p, a);
        check("pointer ack", 16'(a), 16'h1);
        i_master.start();
        i_master.wr_byte({DEV_ADDR, DIR_READ}, a);
        check("read address ack", 16'(a), 16'h1);
        for (int k = 0; k < n; k++)
        begin
            i_master.rd_byte(1'b1, hi);
            i_master.rd_byte(k < n - 1, lo);
            check("read word", {hi, lo}, shadow[p]);
        end
        repeat (8) @(posedge i_link_clk);
        check("sda after nack", 16'(o_sda_oe), 16'h0);
        i_master.stop();
    endtask

    initial
    begin
        logic a;
        i_rst = 1'b1;
        stall = 1'b0;
        i_wr_ready = 1'b0;
        i_rd_valid = 1'b0;
        i_rd_data = 16'h0000;
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = {i[7:0], 8'h5a ^ i[7:0]};
            shadow[i] = mem[i];
        end
        repeat (20) @(posedge i_clk);
        check("sda in reset", 16'(o_sda_oe), 16'h0);
        #2 i_rst = 1'b0;
        repeat (10) @(posedge i_link_clk);
        rnd = $random(seed);
        open_wr(DEV_ADDR, 1'b1);
        put_word(8'hff, rnd[15:0], 1'b1);
        put_word(8'h00, 16'h0000, 1'b1);
        i_master.stop();
        drain();
        get_word(8'h00, 1);
        get_word(8'hff, 1);
        $display("test single words done");
        open_wr(DEV_ADDR, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            rnd = $random(seed);
            put_word(rnd[23:16], rnd[15:0], 1'b1);
        end
        i_master.stop();
        drain();
        get_word(rnd[23:16], 3);
        $display("test multi word done");
        open_wr(DEV_ADDR ^ 7'h01, 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            i_master.wr_byte(8'h00 + i[7:0], a);
            check("foreign byte ack", 16'(a), 16'h0);
        end
        i_master.stop();
        open_wr(DEV_ADDR, 1'b1);
        i_master.wr_byte(8'h00, a);
        i_master.wr_byte(8'hab, a);
        i_master.stop();
        drain();
        get_word(8'h00, 1);
        $display("test foreign and partial done");
        stall = 1'b1;
        open_wr(DEV_ADDR, 1'b1);
        for (int i = 0; i <= WR_FIFO_DEPTH; i++)
        begin
            rnd = $random(seed);
            put_word(8'h80 + i[7:0], rnd[15:0], fifo_room(i));
        end
        i_master.stop();
        check("valid while stalled", 16'(o_wr_valid), 16'h1);
        stall = 1'b0;
        drain();
        get_word(8'h80, 1);
        get_word(8'ha0, 1);
        $display("test buffer full done");
        report_and_stop();
    end
endmodule

`default_nettype wire
